// [pkg/aph_params.svh]
// Register offsets, field positions and reset values of the parallel host port
`ifndef APH_PARAMS_SVH
`define APH_PARAMS_SVH
`define APH_OFF_CFG 12'h000
`define APH_OFF_DATA0 12'h004
`define APH_OFF_DATA1 12'h008
`define APH_OFF_DATA2 12'h00c
`define APH_OFF_GPIO_CFG 12'h010
`define APH_OFF_GPIO_OUT 12'h014
`define APH_OFF_STATUS 12'h018
`define APH_CFG_WIDTH_LO 0
`define APH_CFG_WIDTH_HI 1
`define APH_CFG_VALID_BIT 2
`define APH_CFG_VACANT_BIT 3
`define APH_CFG_VPOL_BIT 4
`define APH_CFG_LPOL_BIT 5
`define APH_CFG_RESET 8'h03
`define APH_GPIO_CFG_RESET 8'h00
`define APH_FIFO_DEPTH 32
`endif

// [pkg/aph_pkg.sv]
// Types of the parallel host port
package aph_pkg;
  typedef enum logic [1:0] {
    APH_W8 = 2'h0,
    APH_W16 = 2'h1,
    APH_W24 = 2'h2,
    APH_OFF = 2'h3
  } aph_width_t;
  typedef logic [23:0] aph_word_t;
endpackage : aph_pkg

// [verilog/aph_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides
module aph_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : aph_fifo

// [verilog/aph_port.sv]
// Assisted parallel host port with APB register access
`include "aph_params.svh"
module aph_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [23:0] port_in,
  output logic [23:0] port_out,
  output logic [23:0] port_oe,
  output logic output_valid_out,
  output logic latch_vacant_out,
  output logic ctrl_pull_down_en,
  output logic port_event
);
  import aph_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] gpio_cfg_r;
  logic [23:0] gpio_out_r;
  aph_word_t out_latch_r;
  aph_word_t in_latch_r;
  logic valid_r;
  logic vacant_r;
  logic ws_d_r;
  logic oe_d_r;
  logic [7:0] ovf_cnt_r;
  aph_width_t width;
  logic enabled;
  logic wr_en;
  logic rd_en;
  logic ws_act;
  logic oe_act;
  logic ws_rise;
  logic oe_rise;
  logic [23:0] lane_mask;
  logic valid_flag;
  logic vacant_flag;
  logic fifo_in_ready;
  aph_word_t fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;

  assign width = aph_width_t'(cfg_r[`APH_CFG_WIDTH_HI:`APH_CFG_WIDTH_LO]);
  assign enabled = (width != APH_OFF);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Byte lanes in use per width
  always_comb begin
    unique case (width)
      APH_W8: lane_mask = 24'h0000ff;
      APH_W16: lane_mask = 24'h00ffff;
      APH_W24: lane_mask = 24'hffffff;
      APH_OFF: lane_mask = 24'h000000;
    endcase
  end

  // ------------------------------------------------------------
  // External strobes
  // ------------------------------------------------------------
  assign ws_act = enabled && !chip_select_n && !write_strobe_n;
  assign oe_act = enabled && !chip_select_n && !output_enable_n;
  assign ws_rise = ws_d_r && !ws_act;
  assign oe_rise = oe_d_r && !oe_act;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_d_r <= 1'b0;
      oe_d_r <= 1'b0;
      port_event <= 1'b0;
    end else begin
      ws_d_r <= ws_act;
      oe_d_r <= oe_act;
      port_event <= ws_rise || oe_rise;
    end
  end

  // Incoming words queue behind the latch; firmware drains via data0 read
  aph_fifo #(
    .WIDTH(24),
    .DEPTH(`APH_FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(port_in & lane_mask),
    .in_valid(ws_act && !ws_d_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );
  assign fifo_pop = rd_en && (paddr == `APH_OFF_DATA0) && vacant_r == 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_cnt_r <= 8'h00;
    end else if (ws_act && !ws_d_r && !fifo_in_ready) begin
      ovf_cnt_r <= ovf_cnt_r + 8'h01;
    end
  end

  // Incoming latch follows the FIFO head
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_latch_r <= '0;
    end else if (fifo_out_valid) begin
      in_latch_r <= fifo_out;
    end
  end

  // Vacant: strobe or a queued word clears (set wins over both), each data0 read that pops sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vacant_r <= 1'b1;
    end else if (fifo_pop) begin
      vacant_r <= 1'b1;
    end else if (ws_act) begin
      vacant_r <= 1'b0;
    end else if (fifo_out_valid) begin
      vacant_r <= 1'b0;
    end
  end

  // Valid: data0 write sets (wins), OE low clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= 1'b0;
    end else if (wr_en && paddr == `APH_OFF_DATA0) begin
      valid_r <= 1'b1;
    end else if (oe_act) begin
      valid_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `APH_CFG_RESET;
      gpio_cfg_r <= `APH_GPIO_CFG_RESET;
      gpio_out_r <= '0;
      out_latch_r <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        `APH_OFF_CFG: begin
          cfg_r[1:0] <= pwdata[1:0];
          cfg_r[`APH_CFG_VPOL_BIT] <= pwdata[`APH_CFG_VPOL_BIT];
          cfg_r[`APH_CFG_LPOL_BIT] <= pwdata[`APH_CFG_LPOL_BIT];
          cfg_r[7:6] <= pwdata[7:6];
        end
        `APH_OFF_DATA0: out_latch_r[7:0] <= pwdata[7:0];
        `APH_OFF_DATA1: out_latch_r[15:8] <= pwdata[7:0];
        `APH_OFF_DATA2: out_latch_r[23:16] <= pwdata[7:0];
        `APH_OFF_GPIO_CFG: gpio_cfg_r <= pwdata[7:0];
        `APH_OFF_GPIO_OUT: gpio_out_r <= pwdata[23:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Flags and pins
  // ------------------------------------------------------------
  // Pin active high with polarity 0; flag is pin inverted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_valid_out <= 1'b0;
      latch_vacant_out <= 1'b0;
    end else begin
      output_valid_out <= enabled && (valid_r ^ cfg_r[`APH_CFG_VPOL_BIT]);
      latch_vacant_out <= enabled && (vacant_r ^ cfg_r[`APH_CFG_LPOL_BIT]);
    end
  end
  assign valid_flag = !output_valid_out;
  assign vacant_flag = !latch_vacant_out;

  // Port data: host port overrides GPIO setting when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out <= '0;
      port_oe <= '0;
      ctrl_pull_down_en <= 1'b1;
    end else if (enabled) begin
      port_out <= out_latch_r & lane_mask;
      port_oe <= oe_act ? lane_mask : 24'h000000;
      ctrl_pull_down_en <= 1'b0;
    end else begin
      port_out <= gpio_out_r;
      port_oe <= {24{gpio_cfg_r[0]}};
      ctrl_pull_down_en <= gpio_cfg_r[1];
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always_comb begin
    prdata = 32'h00000000;
    if (rd_en) begin
      unique case (paddr)
        `APH_OFF_CFG: prdata = {24'h000000, cfg_r[7:6], cfg_r[5:4],
                                vacant_flag, valid_flag, cfg_r[1:0]};
        `APH_OFF_DATA0: prdata = {24'h000000, in_latch_r[7:0]};
        `APH_OFF_DATA1: prdata = {24'h000000, in_latch_r[15:8]};
        `APH_OFF_DATA2: prdata = {24'h000000, in_latch_r[23:16]};
        `APH_OFF_GPIO_CFG: prdata = {24'h000000, gpio_cfg_r};
        `APH_OFF_GPIO_OUT: prdata = {8'h00, gpio_out_r};
        `APH_OFF_STATUS: prdata = {16'h0000, ovf_cnt_r, 7'h00, fifo_out_valid};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule : aph_port

// [sim/aph_port_assertions.sv]
// Checker of the parallel host port pins and flags
module aph_port_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [23:0] port_oe,
  input wire logic output_valid_out,
  input wire logic latch_vacant_out,
  input wire logic ctrl_pull_down_en,
  input wire logic port_event
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg_r;
  logic acc;
  logic en;
  logic [23:0] mask;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign acc = psel && penable;
  assign en = cfg_r[1:0] != 2'h3;
  assign mask = cfg_r[1] ? 24'hffffff : (cfg_r[0] ? 24'h00ffff : 24'h0000ff);
  // Shadow of the configuration byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h03;
    end else if (acc && pwrite && paddr == 12'h000) begin
      cfg_r <= pwdata[7:0];
    end
  end
  // ----------
  // Properties
  // ----------
  a_pull_down_off: assert property (en [*2] |-> !ctrl_pull_down_en)
    else $error("pull-down on");
  a_lane_mask: assert property (
    en [*2] ##0 port_oe != 24'h0 |-> port_oe == mask && !$past(output_enable_n)
      && !$past(chip_select_n))
    else $error("bad lanes");
  a_flag_inverse: assert property (
    acc && !pwrite && paddr == 12'h000 |-> prdata[2] != output_valid_out
      && prdata[3] != latch_vacant_out)
    else $error("flag not inverse");
  a_valid_set: assert property (
    acc && pwrite && paddr == 12'h004 && en && output_enable_n |-> ##[2:3]
      output_valid_out != cfg_r[4])
    else $error("valid not set");
  a_valid_clear: assert property (
    $fell(output_enable_n) && !chip_select_n && en |-> ##[1:3] output_valid_out == cfg_r[4])
    else $error("valid not cleared");
  a_vacant_set: assert property (
    acc && !pwrite && paddr == 12'h004 && en && write_strobe_n |-> ##[1:3]
      latch_vacant_out != cfg_r[5])
    else $error("vacant not set");
  a_vacant_clear: assert property (
    $fell(write_strobe_n) && !chip_select_n && en |-> ##[1:3] latch_vacant_out == cfg_r[5])
    else $error("vacant not cleared");
  a_end_event: assert property (
    ($rose(output_enable_n) || $rose(write_strobe_n)) && !chip_select_n && en |-> ##[1:3]
      port_event)
    else $error("no event");
endmodule : aph_port_assertions

// [sim/aph_host_model.sv]
// Model of the external controller on the parallel pins
module aph_host_model (
  input wire logic pclk,
  input wire logic [23:0] port_out,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic [23:0] port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    port_in = 24'h0;
  end
  // Strobe one word in; released data shows its inverse
  task automatic ext_write(input logic [23:0] d, input int hold, input logic sel);
    @(posedge pclk);
    chip_select_n <= !sel;
    write_strobe_n <= 1'b0;
    port_in <= d;
    repeat (hold) @(posedge pclk);
    write_strobe_n <= 1'b1;
    @(posedge pclk);
    chip_select_n <= 1'b1;
    port_in <= ~d;
  endtask : ext_write
  // Fetch one word while select and enable are low
  task automatic ext_read(output logic [23:0] d, input int hold);
    @(posedge pclk);
    chip_select_n <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (hold) @(posedge pclk);
    d = port_out;
    output_enable_n <= 1'b1;
    @(posedge pclk);
    chip_select_n <= 1'b1;
  endtask : ext_read
endmodule : aph_host_model

// [sim/tb_aph_port.sv]
// Self-checking bench of the parallel host port
module tb_aph_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, output_valid_out, latch_vacant_out;
  logic ctrl_pull_down_en, port_event, chip_select_n, write_strobe_n, output_enable_n;
  logic pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [23:0] port_in, port_out, port_oe, m, d, rx;
  logic [7:0] c;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  aph_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .chip_select_n, .write_strobe_n, .output_enable_n, .port_in, .port_out,
    .port_oe, .output_valid_out, .latch_vacant_out, .ctrl_pull_down_en, .port_event);
  aph_host_model u_host (.pclk, .port_out, .chip_select_n, .write_strobe_n, .output_enable_n,
    .port_in);
  // ----------
  // Tasks
  // ----------
  task automatic complete_run;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("cfg", rdat, 32'h0f);
    chk("pd", 32'(ctrl_pull_down_en), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", rdat, 32'h0);
    chk("slverr", 32'(pslverr), 32'h0);
    apb(1'b1, 12'h010, 32'h3);
    repeat (2) @(posedge pclk);
    chk("gpio", 32'(port_oe), 32'hffffff);
    chk("gpio pd", 32'(ctrl_pull_down_en), 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    repeat (2) @(posedge pclk);
    chk("override", 32'(port_oe), 32'h0);
    chk("pd", 32'(ctrl_pull_down_en), 32'h0);
    for (int i = 0; i < 3; i++) begin
      m = i == 0 ? 24'h0000ff : (i == 1 ? 24'h00ffff : 24'hffffff);
      c = {2'h0, i[1], i[0], 2'h0, i[1:0]};
      d = 24'ha5c3e1 + 24'(i);
      apb(1'b1, 12'h000, 32'(c));
      apb(1'b1, 12'h008, 32'(d[15:8]));
      apb(1'b1, 12'h00c, 32'(d[23:16]));
      chk("early", 32'(output_valid_out), 32'(c[4]));
      apb(1'b1, 12'h004, 32'(d[7:0]));
      repeat (3) @(posedge pclk);
      chk("valid", 32'(output_valid_out), 32'(!c[4]));
      u_host.ext_read(rx, 2);
      chk("rdata", 32'(rx & m), 32'(d & m));
      @(posedge pclk);
      chk("oe event", 32'(port_event), 32'h1);
      u_host.ext_write(~d, 2, 1'b1);
      chk("full", 32'(latch_vacant_out), 32'(c[5]));
      @(posedge pclk);
      chk("stb event", 32'(port_event), 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk("in1", rdat, 32'(((~d & m) >> 8) & 24'hff));
      apb(1'b0, 12'h004, 32'h0);
      chk("in0", rdat, {24'h000000, ~d[7:0]});
    end
    u_host.ext_write(24'h123456, 2, 1'b0);
    apb(1'b0, 12'h018, 32'h0);
    chk("nosel", rdat & 32'h1, 32'h0);
    for (int k = 0; k < 33; k++) u_host.ext_write(24'(k), 1, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    chk("overflow", rdat & 32'hff01, 32'h0101);
    for (int k = 0; k < 32; k++) begin
      apb(1'b0, 12'h004, 32'h0);
      chk("pop", rdat, 32'(k));
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("drained", rdat & 32'h1, 32'h0);
    complete_run();
  end
endmodule : tb_aph_port
bind aph_port aph_port_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .chip_select_n, .write_strobe_n, .output_enable_n, .port_oe,
  .output_valid_out, .latch_vacant_out, .ctrl_pull_down_en, .port_event);
